/* core/eeprom_pkg.sv */
// shared types and constants for the two-wire serial eeprom device logic
package eeprom_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned MEM_BYTES = 1024;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned PAGE_ADDR_W = 4;
    localparam int unsigned ROW_W = ADDR_W - PAGE_ADDR_W;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam int unsigned DEV_TYPE_MSB = 7;
    localparam int unsigned DEV_TYPE_LSB = 4;
    localparam int unsigned DEV_STRAP_POS = 3;
    localparam int unsigned DEV_HI_MSB = 2;
    localparam int unsigned DEV_HI_LSB = 1;
    localparam int unsigned DEV_RW_POS = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    // longest self-timed write cycle, counted at the core clock
    localparam int unsigned INTERNAL_WRITE_TIME_US = 4000;
    localparam int unsigned CORE_CLK_KHZ = 20000;
    localparam int unsigned WRITE_CYCLES = INTERNAL_WRITE_TIME_US * CORE_CLK_KHZ / 1000;
    localparam logic [3:0] PINS_RESET = 4'hc;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic chip_select_strap;
    } pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_WORD,
        ST_WDATA,
        ST_RDATA
    } phase_t;

    typedef struct packed {
        phase_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [ADDR_W-1:0] addr;
        logic [1:0] hi;
        logic mack;
        logic oe_n;
        logic sda_o;
        logic scl_p;
        logic sda_p;
        logic [PAGE_BYTES-1:0][7:0] page;
        logic [PAGE_BYTES-1:0] mask;
        logic [ROW_W-1:0] row;
        logic wr_pend;
        logic wr_go;
        logic standby;
    } dev_state_t;
endpackage

/* core/pin_sync.sv */
// two-flop synchroniser for a group of pins from outside the core clock
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) $error("pin_sync needs at least one bit");
    end

    // meta_q feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* core/write_timer.sv */
// self-timed write cycle counter: busy from start until the count expires
`timescale 1ns/100ps
module write_timer #(
    parameter int unsigned CYCLES = 80000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;

    initial begin
        if (CYCLES < 1) $error("write_timer needs at least one cycle");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_q <= CW'(CYCLES - 1);
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt_q == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

/* core/i2c_eeprom.sv */
// two-wire serial eeprom, 1024 bytes in 64 pages of 16, device side
`timescale 1ns/100ps
module i2c_eeprom
    import eeprom_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES_P = eeprom_pkg::WRITE_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic WP,
    input wire logic CHIP_SELECT_STRAP,
    output logic STANDBY
);
    import eeprom_pkg::*;

    pins_t pins_raw;
    pins_t pin;
    dev_state_t s;
    dev_state_t n;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic rx_phase;
    logic tx_phase;
    logic wr_busy;
    logic wr_done;
    logic [7:0] rd_byte;
    logic [7:0] mem [MEM_BYTES];

    // idle bus, no transfer, no write data; the array itself is not part of reset
    localparam dev_state_t IDLE_STATE = '{
        st: ST_IDLE,
        bit_cnt: 4'h0,
        shreg: 8'h00,
        addr: '0,
        hi: 2'h0,
        mack: 1'b0,
        oe_n: 1'b1,
        sda_o: 1'b0,
        scl_p: 1'b1,
        sda_p: 1'b1,
        page: '0,
        mask: '0,
        row: '0,
        wr_pend: 1'b0,
        wr_go: 1'b0,
        standby: 1'b1
    };

    initial begin
        if (WRITE_CYCLES_P < 1) $error("write cycle count must be at least one");
        // a longer count would break the promised bound on the timed write
        if (WRITE_CYCLES_P > WRITE_CYCLES) begin
            $error("write cycle count exceeds the longest timed write");
        end
        if (PAGE_BYTES != (1 << PAGE_ADDR_W)) begin
            $error("page size must match the in-page address width");
        end
        if (MEM_BYTES != (1 << ADDR_W)) begin
            $error("array size must match the address width");
        end
        if (ROW_W + PAGE_ADDR_W != ADDR_W) begin
            $error("row and in-page address must fill the address");
        end
        if (DEV_TYPE_MSB - DEV_TYPE_LSB != 3) begin
            $error("device type field must be four bits");
        end
        if (DEV_HI_MSB - DEV_HI_LSB != 1 || DEV_HI_MSB + 1 != DEV_STRAP_POS) begin
            $error("page select field must sit just below the strap bit");
        end
        if (DEV_RW_POS != 0) begin
            $error("direction bit must be the last bit of the address word");
        end
        if (BITS_PER_BYTE != 4'h8 || ACK_SLOT != BITS_PER_BYTE + 4'h1) begin
            $error("byte framing counts are inconsistent");
        end
    end

    function automatic logic dev_match(input logic [7:0] b, input logic strap);
        logic type_ok;
        logic strap_ok;
        type_ok = b[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE;
        strap_ok = b[DEV_STRAP_POS] == strap;
        return type_ok && strap_ok;
    endfunction

    function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:PAGE_ADDR_W], a[PAGE_ADDR_W-1:0] + 1'b1};
    endfunction

    // reads run across the whole array and wrap from the last byte to the first
    function automatic logic [ADDR_W-1:0] array_step(input logic [ADDR_W-1:0] a);
        return a + 1'b1;
    endfunction

    function automatic logic [ADDR_W-1:0] slot_addr(input logic [ROW_W-1:0] row, input logic [PAGE_ADDR_W-1:0] col);
        return {row, col};
    endfunction

    // msb travels first in both directions
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic bit_in);
        return {b[6:0], bit_in};
    endfunction

    assign pins_raw = '{
        scl: SCL,
        sda: SDA_IN,
        wp: WP,
        chip_select_strap: CHIP_SELECT_STRAP
    };

    pin_sync #(
        .W(4),
        .INIT(PINS_RESET)
    ) u_sync (
        .clk(CORE_CLK),
        .rst(RST),
        .d(pins_raw),
        .q(pin)
    );

    write_timer #(
        .CYCLES(WRITE_CYCLES_P)
    ) u_timer (
        .clk(CORE_CLK),
        .rst(RST),
        .start(s.wr_go),
        .busy(wr_busy),
        .done(wr_done)
    );

    // line events seen on the synchronised copies
    assign scl_rise = pin.scl && !s.scl_p;
    assign scl_fall = !pin.scl && s.scl_p;
    assign start_seen = pin.scl && s.scl_p && s.sda_p && !pin.sda;
    assign stop_seen = pin.scl && s.scl_p && !s.sda_p && pin.sda;
    // bytes flow in during address and write phases, out during reads
    assign rx_phase = s.st == ST_DEV || s.st == ST_WORD || s.st == ST_WDATA;
    assign tx_phase = s.st == ST_RDATA;
    assign rd_byte = mem[s.addr];

    always_comb begin
        n = s;
        n.scl_p = pin.scl;
        n.sda_p = pin.sda;
        n.sda_o = 1'b0;
        n.wr_go = 1'b0;
        if (start_seen) begin
            // any half-received byte or unsent write data is dropped
            n.st = ST_DEV;
            n.bit_cnt = '0;
            n.oe_n = 1'b1;
            n.wr_pend = 1'b0;
        end else if (stop_seen) begin
            n.st = ST_IDLE;
            n.oe_n = 1'b1;
            if (s.wr_pend) begin
                n.wr_go = 1'b1;
                n.wr_pend = 1'b0;
            end
        end else if (s.st != ST_IDLE) begin
            if (scl_rise) begin
                if (s.bit_cnt < BITS_PER_BYTE) begin
                    if (rx_phase) begin
                        n.shreg = shift_in(s.shreg, pin.sda);
                    end
                    n.bit_cnt = s.bit_cnt + 1'b1;
                end else if (s.bit_cnt == ACK_SLOT && tx_phase) begin
                    // controller acknowledge decides whether another byte follows
                    n.mack = !pin.sda;
                end
            end else if (scl_fall) begin
                if (s.bit_cnt == BITS_PER_BYTE) begin
                    n.bit_cnt = ACK_SLOT;
                    if (tx_phase) begin
                        n.oe_n = 1'b1;
                        n.mack = 1'b0;
                    end else begin
                        unique case (s.st)
                            ST_DEV: begin
                                // no acknowledge while the timed write runs
                                if (dev_match(s.shreg, pin.chip_select_strap) && !wr_busy) begin
                                    n.oe_n = 1'b0;
                                    n.hi = s.shreg[DEV_HI_MSB:DEV_HI_LSB];
                                    if (s.shreg[DEV_RW_POS]) begin
                                        n.st = ST_RDATA;
                                        n.mack = 1'b1;
                                    end else begin
                                        n.st = ST_WORD;
                                    end
                                end else begin
                                    n.st = ST_IDLE;
                                end
                            end
                            ST_WORD: begin
                                // page bits come from the address word ahead of this byte
                                n.oe_n = 1'b0;
                                n.addr = {s.hi, s.shreg};
                                n.mask = '0;
                                n.st = ST_WDATA;
                            end
                            ST_WDATA: begin
                                n.oe_n = 1'b0;
                                // protected bytes are still acknowledged, only not kept
                                if (!pin.wp) begin
                                    n.page[s.addr[PAGE_ADDR_W-1:0]] = s.shreg;
                                    n.mask[s.addr[PAGE_ADDR_W-1:0]] = 1'b1;
                                    n.row = s.addr[ADDR_W-1:PAGE_ADDR_W];
                                    n.wr_pend = 1'b1;
                                end
                                n.addr = page_step(s.addr);
                            end
                            default: begin
                                n.st = ST_IDLE;
                            end
                        endcase
                    end
                end else if (s.bit_cnt == ACK_SLOT) begin
                    n.bit_cnt = '0;
                    n.oe_n = 1'b1;
                    if (tx_phase) begin
                        if (s.mack) begin
                            // counter moves past the byte now on its way out
                            n.shreg = rd_byte;
                            n.oe_n = rd_byte[7];
                            n.addr = array_step(s.addr);
                            n.mack = 1'b0;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end else if (tx_phase && s.bit_cnt != '0) begin
                    n.shreg = shift_in(s.shreg, 1'b0);
                    n.oe_n = s.shreg[6];
                end
            end
        end
        // stays low from the closing stop until the array has taken the page
        n.standby = n.st == ST_IDLE
            && !n.wr_go
            && !s.wr_go
            && !wr_busy
            && !wr_done;
    end

    // one register holds the whole device state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s <= IDLE_STATE;
        end else begin
            s <= n;
        end
    end

    // array holds no reset; contents change only when the timed write completes
    always_ff @(posedge CORE_CLK) begin
        if (wr_done) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (s.mask[i]) begin
                    mem[slot_addr(s.row, PAGE_ADDR_W'(i))] <= s.page[i];
                end
            end
        end
    end

    // open drain: the pad only ever pulls low, so the driven value is fixed
    assign SDA_OUT = s.sda_o;
    assign SDA_OE_N = s.oe_n;
    assign STANDBY = s.standby;
endmodule

/* tb/eeprom_properties.sv */
// concurrent checks on the eeprom device pins
`timescale 1ns/100ps
module eeprom_properties #(
    parameter int unsigned WRITE_CYCLES_P = 80000
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    input wire logic WP,
    input wire logic CHIP_SELECT_STRAP,
    input wire logic STANDBY
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    logic [31:0] idle_q;
    // counts a quiet bus while busy; only the timed write may run that long
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            idle_q <= '0;
        end else if (STANDBY || !SCL) begin
            idle_q <= '0;
        end else begin
            idle_q <= idle_q + 32'h1;
        end
    end
    property p_open_drain; !SDA_OE_N |-> SDA_OUT == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda driven high");
    property p_drive_low; $changed(SDA_OE_N) |-> !$past(SCL, 1) && !$past(SCL, 2); endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda changed near scl high");
    property p_drive_stands; $fell(SDA_OE_N) |-> !SDA_OE_N [*7]; endproperty
    a_drive_stands: assert property (p_drive_stands) else $error("sda drive too short");
    property p_reset_idle; $fell(RST) |-> STANDBY && SDA_OE_N; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_idle_quiet; STANDBY |-> SDA_OE_N; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive in standby");
    property p_write_bound; idle_q <= 32'(WRITE_CYCLES_P + 8); endproperty
    a_write_bound: assert property (p_write_bound) else $error("timed write too long");
    property p_prot_stop; SCL && $past(SCL) && $rose(SDA_IN) && WP |-> ##[1:8] STANDBY; endproperty
    a_prot_stop: assert property (p_prot_stop) else $error("protected stop not idle");
    property p_start_wake; SCL && $past(SCL) && $fell(SDA_IN) |-> ##[1:6] !STANDBY; endproperty
    a_start_wake: assert property (p_start_wake) else $error("start ignored");
endmodule

/* tb/host.sv */
// bus controller model: scl and sda pull-down paced by the core clock
`timescale 1ns/100ps
module host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_rel
);
    // idle bus: clock stands high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // data moves one clock after scl falls and holds through the high phase
    task automatic bitx(input logic b, output logic r);
        @(posedge clk);
        sda_rel <= b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        r = sda;
        repeat (2) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic start;
        @(posedge clk);
        sda_rel <= 1'b1;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_rel <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop;
        @(posedge clk);
        sda_rel <= 1'b0;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_rel <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(~more, r);
    endtask
    task automatic recover;
        logic r;
        r = 1'b0;
        for (int n = 0; n < 9 && !r; n++) begin
            bitx(1'b1, r);
        end
    endtask
endmodule

/* tb/i2c_eeprom_tb_top.sv */
// self-checking bench for the two-wire eeprom device logic
`timescale 1ns/100ps
module i2c_eeprom_tb_top;
    import eeprom_pkg::*;
    // short timed write so polls land both during and after it
    localparam int unsigned WCYC = 400;
    logic clk;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic strap = 1'b1;
    logic scl, sda_rel, sda_out, sda_oe_n, standby, a;
    logic [7:0] d;
    int error_cnt = 0;
    int samples_checked = 0;
    wire sda = sda_rel & (sda_oe_n | sda_out);
    i2c_eeprom #(.WRITE_CYCLES_P(WCYC)) u_i2c_eeprom (.CORE_CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .WP(wp), .CHIP_SELECT_STRAP(strap), .STANDBY(standby));
    host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] dw(input logic [1:0] hi, input logic rd);
        return {DEV_TYPE_CODE, 1'b1, hi, rd};
    endfunction
    task automatic wr(input logic [7:0] v);
        u_host.wbyte(v, a);
        chk({7'h00, a}, 8'h01);
    endtask
    task automatic seek(input logic [9:0] adr);
        u_host.start();
        wr(dw(adr[9:8], 1'b0));
        wr(adr[7:0]);
    endtask
    task automatic rd_open;
        u_host.start();
        wr(dw(2'b00, 1'b1));
    endtask
    task automatic rd(input logic [7:0] exp, input logic more);
        u_host.rbyte(more, d);
        chk(d, exp);
    endtask
    task automatic poll;
        a = 1'b0;
        for (int n = 0; n < 50 && !a; n++) begin
            u_host.start();
            u_host.wbyte(dw(2'b00, 1'b0), a);
            u_host.stop();
        end
        chk({7'h00, a}, 8'h01);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        chk({6'h00, standby, sda_oe_n}, 8'h03);
        u_host.recover();
        seek(10'h3ff);
        wr(8'ha5);
        u_host.stop();
        chk({7'h00, standby}, 8'h00);
        u_host.start();
        u_host.wbyte(dw(2'b11, 1'b0), a);
        u_host.stop();
        chk({7'h00, a}, 8'h00);
        poll();
        seek(10'h3ff);
        rd_open();
        rd(8'ha5, 1'b0);
        u_host.stop();
        $display("byte write test end");
        seek(10'h00e);
        for (int k = 0; k < 18; k++) begin
            wr(8'h40 + 8'(k));
        end
        u_host.stop();
        poll();
        seek(10'h000);
        rd_open();
        for (int o = 0; o < 16; o++) begin
            rd(8'h42 + 8'(o), o != 15);
        end
        u_host.stop();
        $display("page write test end");
        seek(10'h3ff);
        rd_open();
        rd(8'ha5, 1'b1);
        rd(8'h42, 1'b0);
        u_host.stop();
        rd_open();
        rd(8'h43, 1'b0);
        u_host.stop();
        $display("wrap read test end");
        u_host.start();
        u_host.wbyte({4'hb, 1'b1, 2'b00, 1'b0}, a);
        chk({7'h00, a}, 8'h00);
        u_host.stop();
        strap <= 1'b0;
        u_host.start();
        u_host.wbyte(dw(2'b00, 1'b0), a);
        chk({7'h00, a}, 8'h00);
        u_host.stop();
        chk({7'h00, standby}, 8'h01);
        strap <= 1'b1;
        $display("refusal test end");
        wp <= 1'b1;
        seek(10'h3ff);
        wr(8'h11);
        u_host.stop();
        chk({7'h00, standby}, 8'h01);
        wp <= 1'b0;
        seek(10'h3ff);
        rd_open();
        rd(8'ha5, 1'b0);
        u_host.stop();
        $display("protect test end");
        u_host.start();
        for (int i = 0; i < 4; i++) begin
            u_host.bitx(1'b1, a);
        end
        rd_open();
        rd(8'h42, 1'b0);
        u_host.stop();
        $display("abort test end");
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule
bind i2c_eeprom eeprom_properties #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_eeprom_properties (.CORE_CLK(CORE_CLK),
    .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .WP(WP),
    .CHIP_SELECT_STRAP(CHIP_SELECT_STRAP), .STANDBY(STANDBY));
